// >>> pkg/efs_regs_regs.svh
/*
 Register offsets, status word fields and counting limits of the
 frame statistics block. Assumes a 32-bit byte address on the register bus.
*/
`ifndef EFS_REGS_REGS_SVH
`define EFS_REGS_REGS_SVH

`define EFS_RXUNI_OFF 32'h3000_3630
`define EFS_RXMUL_OFF 32'h3000_3634
`define EFS_RXBRD_OFF 32'h3000_3638
`define EFS_RXOVF_OFF 32'h3000_363c
`define EFS_RXRUNT_OFF 32'h3000_3640
`define EFS_RXLONG_OFF 32'h3000_3644
`define EFS_RXCRC_OFF 32'h3000_3648
`define EFS_RXDRIB_OFF 32'h3000_364c
`define EFS_RXLEN_OFF 32'h3000_3650
`define EFS_RXTYPE_OFF 32'h3000_3654
`define EFS_TXALL_OFF 32'h3000_3700
`define EFS_TXCTL_OFF 32'h3000_3704
`define EFS_TXBYT_OFF 32'h3000_3708
`define EFS_TXGBYT_OFF 32'h3000_370c
`define EFS_TXL64_OFF 32'h3000_3710
`define EFS_TXL65_OFF 32'h3000_3714
`define EFS_TXL128_OFF 32'h3000_3718
`define EFS_TXL256_OFF 32'h3000_371c
`define EFS_TXL512_OFF 32'h3000_3720
`define EFS_TXL1024_OFF 32'h3000_3724
`define EFS_TXUNI_OFF 32'h3000_3728
`define EFS_TXMUL_OFF 32'h3000_272c
`define EFS_TXBRD_OFF 32'h3000_3730
`define EFS_TXUND_OFF 32'h3000_3734
`define EFS_TXBAD_OFF 32'h3000_3738
`define EFS_TXCOL1_OFF 32'h3000_373c
`define EFS_TXCOLN_OFF 32'h3000_3740
`define EFS_TXDEF_OFF 32'h3000_3744
`define EFS_TXLATE_OFF 32'h3000_3748
`define EFS_TXABT_OFF 32'h3000_374c
`define EFS_TXNOCRS_OFF 32'h3000_3750
`define EFS_TXXSDEF_OFF 32'h3000_3754
`define EFS_CFG_OFF 32'h3000_3780
`define EFS_RXLAST_OFF 32'h3000_3784
`define EFS_TXLAST_OFF 32'h3000_3788

`define EFS_NUM_CNT 32
`define EFS_CFG_FREEZE 16
`define EFS_CFG_LEN_RST 16'h05ee

`define EFS_RX_MISSED 0
`define EFS_RX_RUNT 1
`define EFS_RX_LONG 2
`define EFS_RX_CRC 3
`define EFS_RX_DRIBBLE 4
`define EFS_RX_LENERR 5
`define EFS_RX_TYPE 6
`define EFS_RX_MCAST 7
`define EFS_RX_BCAST 8
`define EFS_RX_ERR_MASK 32'h0000_063f

`define EFS_TX_LEN 15:0
`define EFS_TX_ABORT 16
`define EFS_TX_RETRY 17
`define EFS_TX_HBFAIL 18
`define EFS_TX_UNDERRUN 19
`define EFS_TX_DEFER 20
`define EFS_TX_XSDEF 21
`define EFS_TX_LATECOL 22
`define EFS_TX_NOCRS 23
`define EFS_TX_LOSSCRS 24
`define EFS_TX_CTRL 25
`define EFS_TX_MCAST 26
`define EFS_TX_BCAST 27
`define EFS_TX_COLCNT 31:28
`define EFS_COLCNT_ONE 4'h1

`define EFS_LEN_64 16'h0040
`define EFS_LEN_65 16'h0041
`define EFS_LEN_127 16'h007f
`define EFS_LEN_128 16'h0080
`define EFS_LEN_255 16'h00ff
`define EFS_LEN_256 16'h0100
`define EFS_LEN_511 16'h01ff
`define EFS_LEN_512 16'h0200
`define EFS_LEN_1023 16'h03ff
`define EFS_LEN_1024 16'h0400

`define EFS_RESP_OKAY 2'b00
`define EFS_RESP_SLVERR 2'b10

`endif

// >>> pkg/efs_pkg.sv
/*
 Types of the frame statistics block: counter indices and decode result.
 Assumes the offsets of efs_regs_regs.svh.
*/
package efs_pkg;
    typedef enum logic [4:0] {
        CNT_RX_UNI, CNT_RX_MUL, CNT_RX_BRD, CNT_RX_OVF, CNT_RX_RUNT, CNT_RX_LONG, CNT_RX_CRC,
        CNT_RX_DRIB, CNT_RX_LENERR, CNT_RX_TYPE, CNT_TX_ALL, CNT_TX_CTL, CNT_TX_BYT, CNT_TX_GBYT,
        CNT_TX_L64, CNT_TX_L65, CNT_TX_L128, CNT_TX_L256, CNT_TX_L512, CNT_TX_L1024, CNT_TX_UNI,
        CNT_TX_MUL, CNT_TX_BRD, CNT_TX_UND, CNT_TX_BAD, CNT_TX_COL1, CNT_TX_COLN, CNT_TX_DEF,
        CNT_TX_LATE, CNT_TX_ABT, CNT_TX_NOCRS, CNT_TX_XSDEF
    } efs_cnt_type;

    typedef struct packed {
        logic hit;
        efs_cnt_type idx;
    } efs_hit_type;
endpackage : efs_pkg

// >>> pkg/efs_regbus_if.sv
/*
 Simple register access between the bus port and the counter core.
 Assumes read data and write acceptance are answered in the same cycle.
*/
`timescale 1ns/10ps
interface efs_regbus_if;
    logic [31:0] rdAddr;
    logic [31:0] rdData;
    logic rdOk;
    logic wrReq;
    logic [31:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic wrOk;
    modport port (output rdAddr, input rdData, input rdOk, output wrReq, output wrAddr,
                  output wrData, output wrStrb, input wrOk);
    modport core (input rdAddr, output rdData, output rdOk, input wrReq, input wrAddr,
                  input wrData, input wrStrb, output wrOk);
endinterface : efs_regbus_if

// >>> hw/efs_axil_port.sv
/*
 AXI4-Lite slave port of the frame statistics block.
 Assumes one read and one write outstanding at most; core answers combinationally.
*/
`timescale 1ns/10ps
`include "efs_regs_regs.svh"
module efs_axil_port (
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    efs_regbus_if.port bus
);
    logic [31:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;

    // Address and data may arrive in either order
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            awAddr_q <= 32'h0000_0000;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
            wready <= 1'b1;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                awAddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
        end
    end

    assign bus.wrReq = !awready && !wready && !bvalid;
    assign bus.wrAddr = awAddr_q;
    assign bus.wrData = wData_q;
    assign bus.wrStrb = wStrb_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp <= `EFS_RESP_OKAY;
        end else if (bus.wrReq) begin
            bvalid <= 1'b1;
            bresp <= bus.wrOk ? `EFS_RESP_OKAY : `EFS_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Data is sampled at the address handshake, so a read never sees a torn counter
    assign bus.rdAddr = araddr;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `EFS_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= bus.rdData;
            rresp <= bus.rdOk ? `EFS_RESP_OKAY : `EFS_RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end
endmodule : efs_axil_port

// >>> hw/efs_stat_counters.sv
/*
 Transmit and receive frame statistics counters with an AXI4-Lite register port.
 Assumes the MAC presents one status word per frame with a one-cycle valid strobe.
*/
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "efs_regs_regs.svh"
// Overview of operation
// - Every counter is 32 bits, readable at its own word address.
// - Receive unicast, multicast, broadcast counters count error-free frames only.
// - Receive overflow counter counts frames whose status flags a missed frame.
// - Undersize counter counts received frames flagged as runts.
// - Oversize counter counts received frames flagged too long.
// - Separate receive counters for checksum errors and dribble bits.
// - Receive length error counter follows the length error flag.
// - Receive type-frame counter follows the frame type flag.
// - All-frames transmit counter counts each status, good or bad, no retries.
// - Transmit control counter counts good control frames, no retries.
// - Total transmit byte counter adds every frame's length, no retries.
// - Good byte counter adds length only when abort and retry are clear.
// - Transmit length buckets from 64 up to the configured largest length.
// - Transmit unicast, multicast, broadcast counters count good frames, no retries.
// - Underrun counter counts frames aborted by buffer underrun.
// - Bad transmit counter counts abort or heartbeat failure.
// - Single collision counter: collision count one with retry set.
// - Multiple collision counter: collision count above one with retry set.
// - Separate transmit counters for deferred and excessively deferred frames.
// - Late collision counter follows the late collision flag.
// - Aborted frame counter follows the frame abort flag.
// - No-carrier counter counts no carrier or loss of carrier.
module efs_stat_counters (
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic rxStatValid,
    input wire logic [31:0] rxStatus,
    input wire logic txStatValid,
    input wire logic [31:0] txStatus
);
    efs_regbus_if bus ();

    efs_axil_port u_port (
        .clock(clock),
        .rst(rst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .bus(bus.port)
    );

    function automatic logic inRange(input logic [15:0] len, input logic [15:0] lo, input logic [15:0] hi);
        inRange = (len >= lo) && (len <= hi);
    endfunction : inRange

    function automatic efs_pkg::efs_hit_type decode(input logic [31:0] addr);
        decode.hit = 1'b1;
        decode.idx = efs_pkg::CNT_RX_UNI;
        case (addr)
            `EFS_RXUNI_OFF: decode.idx = efs_pkg::CNT_RX_UNI;
            `EFS_RXMUL_OFF: decode.idx = efs_pkg::CNT_RX_MUL;
            `EFS_RXBRD_OFF: decode.idx = efs_pkg::CNT_RX_BRD;
            `EFS_RXOVF_OFF: decode.idx = efs_pkg::CNT_RX_OVF;
            `EFS_RXRUNT_OFF: decode.idx = efs_pkg::CNT_RX_RUNT;
            `EFS_RXLONG_OFF: decode.idx = efs_pkg::CNT_RX_LONG;
            `EFS_RXCRC_OFF: decode.idx = efs_pkg::CNT_RX_CRC;
            `EFS_RXDRIB_OFF: decode.idx = efs_pkg::CNT_RX_DRIB;
            `EFS_RXLEN_OFF: decode.idx = efs_pkg::CNT_RX_LENERR;
            `EFS_RXTYPE_OFF: decode.idx = efs_pkg::CNT_RX_TYPE;
            `EFS_TXALL_OFF: decode.idx = efs_pkg::CNT_TX_ALL;
            `EFS_TXCTL_OFF: decode.idx = efs_pkg::CNT_TX_CTL;
            `EFS_TXBYT_OFF: decode.idx = efs_pkg::CNT_TX_BYT;
            `EFS_TXGBYT_OFF: decode.idx = efs_pkg::CNT_TX_GBYT;
            `EFS_TXL64_OFF: decode.idx = efs_pkg::CNT_TX_L64;
            `EFS_TXL65_OFF: decode.idx = efs_pkg::CNT_TX_L65;
            `EFS_TXL128_OFF: decode.idx = efs_pkg::CNT_TX_L128;
            `EFS_TXL256_OFF: decode.idx = efs_pkg::CNT_TX_L256;
            `EFS_TXL512_OFF: decode.idx = efs_pkg::CNT_TX_L512;
            `EFS_TXL1024_OFF: decode.idx = efs_pkg::CNT_TX_L1024;
            `EFS_TXUNI_OFF: decode.idx = efs_pkg::CNT_TX_UNI;
            `EFS_TXMUL_OFF: decode.idx = efs_pkg::CNT_TX_MUL;
            `EFS_TXBRD_OFF: decode.idx = efs_pkg::CNT_TX_BRD;
            `EFS_TXUND_OFF: decode.idx = efs_pkg::CNT_TX_UND;
            `EFS_TXBAD_OFF: decode.idx = efs_pkg::CNT_TX_BAD;
            `EFS_TXCOL1_OFF: decode.idx = efs_pkg::CNT_TX_COL1;
            `EFS_TXCOLN_OFF: decode.idx = efs_pkg::CNT_TX_COLN;
            `EFS_TXDEF_OFF: decode.idx = efs_pkg::CNT_TX_DEF;
            `EFS_TXLATE_OFF: decode.idx = efs_pkg::CNT_TX_LATE;
            `EFS_TXABT_OFF: decode.idx = efs_pkg::CNT_TX_ABT;
            `EFS_TXNOCRS_OFF: decode.idx = efs_pkg::CNT_TX_NOCRS;
            `EFS_TXXSDEF_OFF: decode.idx = efs_pkg::CNT_TX_XSDEF;
            default: decode.hit = 1'b0;
        endcase
    endfunction : decode

    // Status words are registered once; they also stay readable as the last seen
    logic rxValid_q;
    logic [31:0] rxStat_q;
    logic txValid_q;
    logic [31:0] txStat_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rxValid_q <= 1'b0;
            rxStat_q <= 32'h0000_0000;
        end else begin
            rxValid_q <= rxStatValid;
            if (rxStatValid) begin
                rxStat_q <= rxStatus;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            txValid_q <= 1'b0;
            txStat_q <= 32'h0000_0000;
        end else begin
            txValid_q <= txStatValid;
            if (txStatValid) begin
                txStat_q <= txStatus;
            end
        end
    end

    // Configuration: largest frame length and a freeze bit
    logic [15:0] largestFrameLength_q;
    logic freeze_q;
    logic cfgWrite;

    assign cfgWrite = bus.wrReq && (bus.wrAddr == `EFS_CFG_OFF);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            largestFrameLength_q <= `EFS_CFG_LEN_RST;
            freeze_q <= 1'b0;
        end else if (cfgWrite) begin
            if (bus.wrStrb[0]) begin
                largestFrameLength_q[7:0] <= bus.wrData[7:0];
            end
            if (bus.wrStrb[1]) begin
                largestFrameLength_q[15:8] <= bus.wrData[15:8];
            end
            if (bus.wrStrb[2]) begin
                freeze_q <= bus.wrData[`EFS_CFG_FREEZE];
            end
        end
    end

    // Per-frame increment decisions
    logic [`EFS_NUM_CNT-1:0] inc;
    logic rxGood;
    logic rxMcast;
    logic rxBcast;
    logic txRetry;
    logic txGood;
    logic txFirst;
    logic txMcast;
    logic txBcast;
    logic [15:0] txLen;
    logic [3:0] txCol;

    always_comb begin
        inc = '0;
        rxGood = (rxStat_q & `EFS_RX_ERR_MASK) == 32'h0000_0000;
        rxMcast = rxStat_q[`EFS_RX_MCAST];
        rxBcast = rxStat_q[`EFS_RX_BCAST];
        txRetry = txStat_q[`EFS_TX_RETRY];
        txFirst = !txRetry;
        txGood = !txStat_q[`EFS_TX_ABORT] && !txRetry;
        txMcast = txStat_q[`EFS_TX_MCAST];
        txBcast = txStat_q[`EFS_TX_BCAST];
        txLen = txStat_q[`EFS_TX_LEN];
        txCol = txStat_q[`EFS_TX_COLCNT];
        if (rxValid_q && !freeze_q) begin
            inc[efs_pkg::CNT_RX_UNI] = rxGood && !rxMcast && !rxBcast;
            inc[efs_pkg::CNT_RX_MUL] = rxGood && rxMcast && !rxBcast;
            inc[efs_pkg::CNT_RX_BRD] = rxGood && rxBcast;
            inc[efs_pkg::CNT_RX_OVF] = rxStat_q[`EFS_RX_MISSED];
            inc[efs_pkg::CNT_RX_RUNT] = rxStat_q[`EFS_RX_RUNT];
            inc[efs_pkg::CNT_RX_LONG] = rxStat_q[`EFS_RX_LONG];
            inc[efs_pkg::CNT_RX_CRC] = rxStat_q[`EFS_RX_CRC];
            inc[efs_pkg::CNT_RX_DRIB] = rxStat_q[`EFS_RX_DRIBBLE];
            inc[efs_pkg::CNT_RX_LENERR] = rxStat_q[`EFS_RX_LENERR];
            inc[efs_pkg::CNT_RX_TYPE] = rxStat_q[`EFS_RX_TYPE];
        end
        if (txValid_q && !freeze_q) begin
            inc[efs_pkg::CNT_TX_ALL] = txFirst;
            inc[efs_pkg::CNT_TX_CTL] = txGood && txStat_q[`EFS_TX_CTRL];
            inc[efs_pkg::CNT_TX_BYT] = txFirst;
            inc[efs_pkg::CNT_TX_GBYT] = txGood;
            inc[efs_pkg::CNT_TX_L64] = txFirst && (txLen == `EFS_LEN_64);
            inc[efs_pkg::CNT_TX_L65] = txFirst && inRange(txLen, `EFS_LEN_65, `EFS_LEN_127);
            inc[efs_pkg::CNT_TX_L128] = txFirst && inRange(txLen, `EFS_LEN_128, `EFS_LEN_255);
            inc[efs_pkg::CNT_TX_L256] = txFirst && inRange(txLen, `EFS_LEN_256, `EFS_LEN_511);
            inc[efs_pkg::CNT_TX_L512] = txFirst && inRange(txLen, `EFS_LEN_512, `EFS_LEN_1023);
            inc[efs_pkg::CNT_TX_L1024] = txFirst && inRange(txLen, `EFS_LEN_1024, largestFrameLength_q);
            inc[efs_pkg::CNT_TX_UNI] = txGood && !txMcast && !txBcast;
            inc[efs_pkg::CNT_TX_MUL] = txGood && txMcast && !txBcast;
            inc[efs_pkg::CNT_TX_BRD] = txGood && txBcast;
            inc[efs_pkg::CNT_TX_UND] = txStat_q[`EFS_TX_UNDERRUN];
            inc[efs_pkg::CNT_TX_BAD] = txStat_q[`EFS_TX_ABORT] || txStat_q[`EFS_TX_HBFAIL];
            inc[efs_pkg::CNT_TX_COL1] = txRetry && (txCol == `EFS_COLCNT_ONE);
            inc[efs_pkg::CNT_TX_COLN] = txRetry && (txCol > `EFS_COLCNT_ONE);
            inc[efs_pkg::CNT_TX_DEF] = txStat_q[`EFS_TX_DEFER];
            inc[efs_pkg::CNT_TX_XSDEF] = txStat_q[`EFS_TX_XSDEF];
            inc[efs_pkg::CNT_TX_LATE] = txStat_q[`EFS_TX_LATECOL];
            inc[efs_pkg::CNT_TX_ABT] = txStat_q[`EFS_TX_ABORT];
            inc[efs_pkg::CNT_TX_NOCRS] = txStat_q[`EFS_TX_NOCRS] || txStat_q[`EFS_TX_LOSSCRS];
        end
    end

    // Counter bank; byte counters add the frame length, all others step by one
    logic [31:0] cnt_q [`EFS_NUM_CNT];
    logic [31:0] txBytes;

    assign txBytes = {16'h0000, txLen};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `EFS_NUM_CNT; i++) begin
                cnt_q[i] <= 32'h0000_0000;
            end
        end else begin
            for (int i = 0; i < `EFS_NUM_CNT; i++) begin
                if (inc[i]) begin
                    // Plain 32-bit add: wraps around past the top, no saturation
                    if (i == int'(efs_pkg::CNT_TX_BYT) || i == int'(efs_pkg::CNT_TX_GBYT)) begin
                        cnt_q[i] <= cnt_q[i] + txBytes;
                    end else begin
                        cnt_q[i] <= cnt_q[i] + 32'h0000_0001;
                    end
                end
            end
        end
    end

    // Register reads; an increment in the same cycle is seen on the next read
    efs_pkg::efs_hit_type rdHit;
    logic [31:0] rdData;
    logic rdOk;

    always_comb begin
        rdHit = decode(bus.rdAddr);
        rdOk = 1'b1;
        rdData = 32'h0000_0000;
        case (bus.rdAddr)
            `EFS_CFG_OFF: begin
                rdData[15:0] = largestFrameLength_q;
                rdData[`EFS_CFG_FREEZE] = freeze_q;
            end
            `EFS_RXLAST_OFF: rdData = rxStat_q;
            `EFS_TXLAST_OFF: rdData = txStat_q;
            default: begin
                if (rdHit.hit) begin
                    rdData = cnt_q[rdHit.idx];
                end else begin
                    rdOk = 1'b0;
                end
            end
        endcase
    end

    assign bus.rdData = rdData;
    assign bus.rdOk = rdOk;

    // Counters are read-only: only the configuration word accepts writes
    assign bus.wrOk = (bus.wrAddr == `EFS_CFG_OFF);
endmodule : efs_stat_counters

// >>> test/efs_stat_counters_sva.sv
/*
 Bus protocol checker for the statistics counter block.
 Assumes the register map of efs_regs_regs.svh and one clock domain.
*/
`timescale 1ns/10ps
`include "efs_regs_regs.svh"
module efs_stat_counters_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence arTaken;
        arvalid && arready;
    endsequence
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer dropped");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer changed early");
    r_latency_a: assert property (arTaken |=> rvalid) else $error("read answer late");
    ar_block_a: assert property (rvalid |-> !arready) else $error("second read accepted");
    w_block_a: assert property (bvalid |-> !awready && !wready) else $error("second write accepted");
    b_latency_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("write answer late");
    unmapped_read_a: assert property (arTaken ##0 araddr == `EFS_TXXSDEF_OFF + 32'h4 |=>
        rresp == `EFS_RESP_SLVERR && rdata == 32'h0) else $error("unmapped read not refused");
    counter_ro_a: assert property (awvalid && awready && wvalid && wready && awaddr == `EFS_TXALL_OFF
        |-> ##2 bresp == `EFS_RESP_SLVERR) else $error("counter write accepted");
    counter_read_a: assert property (arTaken ##0 araddr == `EFS_RXUNI_OFF |=> rresp == `EFS_RESP_OKAY)
        else $error("counter read refused");
    r_done_a: assert property (rvalid && rready |=> !rvalid && arready) else $error("read not retired");
    read_c: cover property (arTaken ##1 rvalid);
    write_c: cover property (bvalid && bready);
    stall_c: cover property (rvalid && !rready);
endmodule : efs_stat_counters_sva
bind efs_stat_counters efs_stat_counters_sva chk_u (.*);

// >>> test/efs_mac_model.sv
/*
 Behavioural MAC core that hands one status word per frame to the counters.
 Assumes the caller invokes send once per clock for back-to-back frames.
*/
`timescale 1ns/10ps
module efs_mac_model (
    input wire logic clock,
    output logic rxStatValid,
    output logic [31:0] rxStatus,
    output logic txStatValid,
    output logic [31:0] txStatus
);
    initial begin
        rxStatValid = 1'b0;
        rxStatus = 32'h0;
        txStatValid = 1'b0;
        txStatus = 32'h0;
    end
    // Idle status lines flip so stale words never look valid
    task automatic send(input logic rv, input logic [31:0] rs, input logic tv, input logic [31:0] ts);
        @(posedge clock);
        rxStatValid <= rv;
        rxStatus <= rv ? rs : ~rxStatus;
        txStatValid <= tv;
        txStatus <= tv ? ts : ~txStatus;
    endtask : send
endmodule : efs_mac_model

// >>> test/efs_stat_counters_tb_top.sv
/*
 Self-checking bench for the statistics counters: random and corner frames, register reads.
 Assumes the register map of efs_regs_regs.svh and the counter order of efs_pkg.
*/
`timescale 1ns/10ps
`include "efs_regs_regs.svh"
module efs_stat_counters_tb_top;
    logic clock, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic rxStatValid, txStatValid, frz;
    logic [31:0] awaddr, wdata, araddr, rdata, rxStatus, txStatus, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [15:0] maxLen;
    logic [31:0] expv [32];
    int n_mismatch, comparisons, seed;
    efs_stat_counters dut_u (.*);
    efs_mac_model mac_u (.*);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    function automatic void apply_rx(logic [31:0] s);
        logic g = (s & `EFS_RX_ERR_MASK) == 32'h0;
        if (frz) return;
        for (int i = 0; i < 7; i++) expv[3 + i] += 32'(s[i]);
        if (g) expv[s[8] ? 2 : (s[7] ? 1 : 0)]++;
    endfunction : apply_rx
    function automatic void apply_tx(logic [31:0] s);
        logic rt = s[17];
        logic g = !s[16] && !s[17];
        logic [15:0] n = s[15:0];
        if (frz) return;
        if (!rt) begin
            expv[10]++;
            expv[12] += 32'(n);
            if (n == `EFS_LEN_64) expv[14]++;
            else if (n >= `EFS_LEN_1024 && n <= maxLen) expv[19]++;
            else for (int b = 6; b < 10; b++) if ((n >> b) == 16'h1) expv[9 + b]++;
        end
        if (g) begin
            expv[11] += 32'(s[25]);
            expv[13] += 32'(n);
            expv[s[27] ? 22 : (s[26] ? 21 : 20)]++;
        end
        expv[23] += 32'(s[19]);
        expv[24] += 32'(s[16] | s[18]);
        expv[25] += 32'(rt && s[31:28] == `EFS_COLCNT_ONE);
        expv[26] += 32'(rt && s[31:28] > `EFS_COLCNT_ONE);
        expv[27] += 32'(s[20]);
        expv[28] += 32'(s[22]);
        expv[29] += 32'(s[16]);
        expv[30] += 32'(s[23] | s[24]);
        expv[31] += 32'(s[21]);
    endfunction : apply_tx
    function automatic logic [31:0] addr_of(int i);
        if (i == int'(efs_pkg::CNT_TX_MUL)) return `EFS_TXMUL_OFF;
        return i < 10 ? `EFS_RXUNI_OFF + 32'(4 * i) : `EFS_TXALL_OFF + 32'(4 * (i - 10));
    endfunction : addr_of
    task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
        @(posedge clock);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            n_mismatch++;
            $display("[FAIL] %0t word %h expected %h", $time, got, want);
        end
    endtask : chk_word
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] want);
        comparisons++;
        if (got !== want) begin
            n_mismatch++;
            $display("[FAIL] %0t response %b expected %b", $time, got, want);
        end
    endtask : chk_resp
    task automatic check_all();
        mac_u.send(1'b0, 32'h0, 1'b0, 32'h0);
        for (int i = 0; i < 32; i++) begin
            rd(addr_of(i));
            chk_word(d, expv[i]);
            chk_resp(r, `EFS_RESP_OKAY);
        end
    endtask : check_all
    task automatic frames(input int n);
        logic [31:0] rs, ts;
        repeat (n) begin
            rs = $random(seed) & ($random(seed) % 2 ? 32'h0000_01c0 : 32'h0000_07ff);
            ts = $random(seed) & 32'hffff_07ff;
            mac_u.send(1'b1, rs, 1'b1, ts);
            apply_rx(rs);
            apply_tx(ts);
        end
    endtask : frames
    task automatic final_report();
        if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    initial begin
        #300000;
        n_mismatch++;
        final_report();
    end
    initial begin
        static logic [31:0] cor [16] = '{32'h40, 32'h3f, 32'h41, 32'h7f, 32'h80, 32'hff, 32'h100, 32'h1ff, 32'h200,
            32'h3ff, 32'h400, 32'h5ee, 32'h5ef, 32'h1002_0040, 32'h3002_0040, 32'h0a0d_0080};
        seed = 16501;
        {rst, awvalid, wvalid, bready, arvalid, rready, frz} = 7'h40;
        {awaddr, wdata, araddr, wstrb} = '0;
        maxLen = `EFS_CFG_LEN_RST;
        expv = '{default: 32'h0};
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        check_all();
        foreach (cor[i]) begin
            mac_u.send(1'b0, 32'h0, 1'b1, cor[i]);
            apply_tx(cor[i]);
        end
        check_all();
        rd(`EFS_TXLAST_OFF);
        chk_word(d, cor[15]);
        frames(300);
        check_all();
        // Shorter largest length moves the top bucket edge
        wr(`EFS_CFG_OFF, 32'h0000_044c, 4'h3);
        maxLen = 16'h044c;
        rd(`EFS_CFG_OFF);
        chk_word(d, 32'h0000_044c);
        frames(300);
        check_all();
        wr(`EFS_CFG_OFF, 32'h0001_044c, 4'h4);
        frz = 1'b1;
        frames(40);
        check_all();
        wr(`EFS_CFG_OFF, 32'h0000_044c, 4'h4);
        frz = 1'b0;
        wr(`EFS_TXALL_OFF, 32'hffff_ffff, 4'hf);
        chk_resp(r, `EFS_RESP_SLVERR);
        rd(`EFS_TXXSDEF_OFF + 32'h4);
        chk_resp(r, `EFS_RESP_SLVERR);
        chk_word(d, 32'h0);
        frames(100);
        check_all();
        final_report();
    end
endmodule : efs_stat_counters_tb_top
